/* logic/flash_host_pkg.sv */
package flash_host_pkg;

	// ----------------------------------------------------------------
	// Clock and timing figures.
	// ----------------------------------------------------------------
	localparam int CLK_PS     = 4000;  // Controller clock period in ps.
	localparam int TAS_NS     = 10;    // Address set-up before strobe.
	localparam int TWP_NS     = 90;    // Write pulse width, least.
	localparam int TWPH_NS    = 100;   // Write pulse high, least.
	localparam int TACC_NS    = 100;   // Address to output delay, most.
	localparam int TOEHP_NS   = 150;   // Output-enable high pulse, least.
	localparam int BYTE_LOAD_WINDOW_US    = 150;   // Byte load window, longest.
	localparam int TWC_MS     = 10;    // Program cycle time, longest.

	// Least times round up to whole cycles.
	localparam int TAS_CYC   = (TAS_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int TWP_CYC   = (TWP_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int TWPH_CYC  = (TWPH_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int TACC_CYC  = (TACC_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int TOEHP_CYC = (TOEHP_NS * 1000 + CLK_PS - 1) / CLK_PS;
	// Longest times round down.
	localparam int BYTE_LOAD_WINDOW_CYC = BYTE_LOAD_WINDOW_US * (1000000 / CLK_PS);
	localparam int TWC_CYC   = TWC_MS * (1000000000 / CLK_PS);

	// ----------------------------------------------------------------
	// Flash geometry and pin positions.
	// ----------------------------------------------------------------
	localparam int FL_AW               = 19;  // Flash address width.
	localparam int SECTOR_BYTES        = 256; // Bytes in one sector.
	localparam int SECTOR_ADDR_LOW_BIT = 8;   // Lowest sector bit.
	localparam int SECTOR_ADDR_HIGH_BIT = 18; // Highest sector bit.
	localparam int CMD_ADDR_BITS       = 15;  // Decoded command bits.
	localparam int TOGGLE_STATUS_LINE  = 6;   // Toggling data line.
	localparam int ADDR_BIT_ZERO       = 0;   // Code select bit.

	// ----------------------------------------------------------------
	// Register map, byte addresses.
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL     = 8'h00; // Start op / busy.
	localparam logic [7:0] REG_ADDR     = 8'h04; // Flash address.
	localparam logic [7:0] REG_WDATA    = 8'h08; // Single write data.
	localparam logic [7:0] REG_RDATA    = 8'h0C; // Last read byte.
	localparam logic [7:0] REG_IRQ_STAT = 8'h10; // Sticky events.
	localparam logic [7:0] REG_IRQ_MASK = 8'h14; // Event mask.
	localparam logic [7:0] REG_BUF_IDX  = 8'h18; // Buffer pointer.
	localparam logic [7:0] REG_BUF_DATA = 8'h1C; // Buffer byte port.

	localparam int EV_DONE    = 0;  // Operation finished.
	localparam int EV_TIMEOUT = 1;  // Program cycle did not end.
	localparam int EV_REFUSED = 2;  // Start while busy.
	localparam int EV_W       = 3;  // Event field width.

	// ----------------------------------------------------------------
	// Operations and bus phases.
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_NONE  = 3'h0,
		OP_WRITE = 3'h1,  // One command or data byte write.
		OP_READ  = 3'h2,  // One array or identification read.
		OP_PROG  = 3'h3,  // Sector load, then completion polling.
		OP_POLL  = 3'h4   // Completion polling only.
	} op_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_WSET = 3'h1,  // Address set up, strobe high; data byte loads at the fall.
		ST_WPUL = 3'h2,  // Write strobe low.
		ST_WREC = 3'h3,  // Write strobe high, hold and recovery.
		ST_RACC = 3'h4,  // Output enable low, access wait.
		ST_RREC = 3'h5   // Output enable high between polls.
	} state_t;

endpackage

/* logic/sector_buf.sv */
`timescale 1ns/1ps

// Sector staging memory; read data come out of a register.
module sector_buf #(
	parameter int W     = 8,    // Word width.
	parameter int DEPTH = 256,  // Words held.
	parameter int AW    = 8     // Address width.
) (
	input  wire logic          i_mclk,   // Clock.
	input  wire logic          i_we,     // Write strobe.
	input  wire logic [AW-1:0] i_waddr,  // Write address.
	input  wire logic [W-1:0]  i_wdata,  // Write data.
	input  wire logic [AW-1:0] i_raddr,  // Read address.
	output logic      [W-1:0]  o_rdata   // Registered read data.
);

	logic [W-1:0] mem_q [DEPTH];  // Storage array.

	// ----------------------------------------------------------------
	// Write port and registered read port.
	// ----------------------------------------------------------------
	// No reset here: contents are defined only once software fills them.
	always_ff @(posedge i_mclk) begin
		if (i_we) begin
			mem_q[i_waddr] <= i_wdata;
		end
		o_rdata <= mem_q[i_raddr];
	end

endmodule

/* logic/flash_host_ctrl.sv */
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps

// Operation
// - see all 256 bytes loaded before programming
// - see sector bits held on each strobe
// - see next load within byte load window
// - see commands decoded on low fifteen bits
// - see poll address held constant
module flash_host_ctrl #(
	parameter int WC_CYC  = flash_host_pkg::TWC_CYC,  // Poll timeout.
	parameter int BLC_CYC = flash_host_pkg::BYTE_LOAD_WINDOW_CYC  // Gap.
) (
	input  wire logic        i_mclk,     // Clock, 250 MHz.
	input  wire logic        i_rst,      // Asynchronous reset, high.
	input  wire logic [7:0]  i_addr,     // Register byte address.
	input  wire logic [31:0] i_wr_data,  // Register write data.
	input  wire logic        i_wr,       // Register write strobe.
	input  wire logic        i_rd,       // Register read strobe.
	output logic      [31:0] o_rd_data,  // Read data, next cycle.
	output logic             o_irq,      // Level interrupt.
	output logic      [18:0] o_fl_addr,  // Flash address pins.
	output logic             o_ce_n,     // Chip select, low active.
	output logic             o_oe_n,     // Output enable, low active.
	output logic             o_we_n,     // Write enable, low active.
	output logic      [7:0]  o_dq_o,     // Data pins, driven value.
	output logic             o_dq_oe,    // Data pins driven when high.
	input  wire logic [7:0]  i_dq_i      // Data pins, sampled value.
);

	localparam int EW = flash_host_pkg::EV_W;  // Event field width.

	flash_host_pkg::state_t state_q;   // Bus phase.
	flash_host_pkg::state_t state_d;   // Next bus phase.
	flash_host_pkg::op_t    op_q;      // Operation in progress.
	logic [5:0]             cnt_q;     // Phase cycle counter.
	logic [21:0]            wc_q;      // Poll timeout counter.
	logic [7:0]             idx_q;     // Byte being loaded.
	logic [18:0]            addr_q;    // Software flash address.
	logic [7:0]             wdata_q;   // Software write byte.
	logic [7:0]             rdata_q;   // Last byte read.
	logic [7:0]             bidx_q;    // Buffer write pointer.
	logic [EW-1:0]          stat_q;    // Sticky event bits.
	logic [EW-1:0]          mask_q;    // Event mask.
	logic                   prev_q;    // Previous toggle value.
	logic                   have_q;    // A previous poll exists.
	logic [7:0]             buf_rdata; // Staged byte for loading.
	logic [EW-1:0]          ev;        // Event pulses this cycle.
	logic                   start;     // Accepted start.
	logic                   phase_end; // Current phase times out.
	logic                   poll_hit;  // Two equal toggle reads.
	logic                   poll_tmo;  // Program cycle overran.
	logic                   in_poll;   // Polling phases.

	// Phase length expressed as a terminal count.
	function automatic logic [5:0] last_cnt(input int cyc);
		return 6'(cyc - 1);
	endfunction

	// Sector number with a byte offset beside it.
	function automatic logic [18:0] sect_addr(input logic [18:0] a,
			input logic [7:0] b);
		return {a[flash_host_pkg::SECTOR_ADDR_HIGH_BIT:
			flash_host_pkg::SECTOR_ADDR_LOW_BIT], b};
	endfunction

	// ----------------------------------------------------------------
	// Staging buffer.
	// ----------------------------------------------------------------
	sector_buf #(
		.W     (8),
		.DEPTH (flash_host_pkg::SECTOR_BYTES),
		.AW    (8)
	) u_buf (
		.i_mclk  (i_mclk),
		.i_we    (i_wr && i_addr == flash_host_pkg::REG_BUF_DATA),
		.i_waddr (bidx_q),
		.i_wdata (i_wr_data[7:0]),
		.i_raddr (idx_q),
		.o_rdata (buf_rdata)
	);

	// ----------------------------------------------------------------
	// Phase decode.
	// ----------------------------------------------------------------
	assign start = i_wr && i_addr == flash_host_pkg::REG_CTRL &&
		state_q == flash_host_pkg::ST_IDLE &&
		i_wr_data[2:0] != flash_host_pkg::OP_NONE &&
		i_wr_data[2:0] <= flash_host_pkg::OP_POLL;
	assign in_poll = state_q == flash_host_pkg::ST_RACC ||
		state_q == flash_host_pkg::ST_RREC;
	// Only a change between reads means anything, so equality of two
	// successive samples marks the end of the program cycle.
	assign poll_hit = have_q && prev_q ==
		i_dq_i[flash_host_pkg::TOGGLE_STATUS_LINE];
	assign poll_tmo = op_q != flash_host_pkg::OP_READ && in_poll &&
		wc_q == 22'(WC_CYC - 1);

	// Next phase; each phase lasts its own time figure, RACC the most access delay, unless a poll timeout ends it.
	always_comb begin
		state_d   = state_q;
		phase_end = 1'b0;
		unique case (state_q)
			flash_host_pkg::ST_IDLE: begin
				if (start) begin
					if (i_wr_data[2:0] == flash_host_pkg::OP_READ ||
							i_wr_data[2:0] == flash_host_pkg::OP_POLL) begin
						state_d = flash_host_pkg::ST_RACC;
					end else begin
						state_d = flash_host_pkg::ST_WSET;
					end
				end
			end
			flash_host_pkg::ST_WSET: begin
				phase_end = cnt_q == last_cnt(flash_host_pkg::TAS_CYC);
				if (phase_end) begin
					state_d = flash_host_pkg::ST_WPUL;
				end
			end
			flash_host_pkg::ST_WPUL: begin
				phase_end = cnt_q == last_cnt(flash_host_pkg::TWP_CYC);
				if (phase_end) begin
					state_d = flash_host_pkg::ST_WREC;
				end
			end
			flash_host_pkg::ST_WREC: begin
				phase_end = cnt_q == last_cnt(flash_host_pkg::TWPH_CYC);
				if (phase_end && op_q == flash_host_pkg::OP_PROG) begin
					// Every byte of the sector goes in before polling.
					if (idx_q == 8'(flash_host_pkg::SECTOR_BYTES - 1)) begin
						state_d = flash_host_pkg::ST_RACC;
					end else begin
						state_d = flash_host_pkg::ST_WSET;
					end
				end else if (phase_end) begin
					state_d = flash_host_pkg::ST_IDLE;
				end
			end
			flash_host_pkg::ST_RACC: begin
				phase_end = cnt_q == last_cnt(flash_host_pkg::TACC_CYC);
				if (poll_tmo) begin
					state_d = flash_host_pkg::ST_IDLE;
				end else if (phase_end) begin
					if (op_q == flash_host_pkg::OP_READ || poll_hit) begin
						state_d = flash_host_pkg::ST_IDLE;
					end else begin
						state_d = flash_host_pkg::ST_RREC;
					end
				end
			end
			flash_host_pkg::ST_RREC: begin
				// Output enable goes high long enough to advance the bit.
				phase_end = cnt_q == last_cnt(flash_host_pkg::TOEHP_CYC);
				if (poll_tmo) begin
					state_d = flash_host_pkg::ST_IDLE;
				end else if (phase_end) begin
					state_d = flash_host_pkg::ST_RACC;
				end
			end
			default: begin
				state_d = flash_host_pkg::ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Sequencer state.
	// ----------------------------------------------------------------
	// Phase, operation and counters move together.
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= flash_host_pkg::ST_IDLE;
			op_q    <= flash_host_pkg::OP_NONE;
			cnt_q   <= 6'h00;
			wc_q    <= 22'h000000;
			idx_q   <= 8'h00;
		end else begin
			state_q <= state_d;
			cnt_q   <= (state_d != state_q) ? 6'h00 : cnt_q + 6'h01;
			if (start) begin
				op_q  <= flash_host_pkg::op_t'(i_wr_data[2:0]);
				idx_q <= 8'h00;
				wc_q  <= 22'h000000;
			end else if (in_poll) begin
				wc_q <= wc_q + 22'h000001;
			end
			if (state_q == flash_host_pkg::ST_WREC &&
					state_d == flash_host_pkg::ST_WSET) begin
				idx_q <= idx_q + 8'h01;
			end
		end
	end

	// Toggle sampling; the first read after a start has no reference.
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			prev_q  <= 1'b0;
			have_q  <= 1'b0;
			rdata_q <= 8'h00;
		end else if (start) begin
			have_q <= 1'b0;
		end else if (state_q == flash_host_pkg::ST_RACC && phase_end) begin
			prev_q  <= i_dq_i[flash_host_pkg::TOGGLE_STATUS_LINE];
			have_q  <= 1'b1;
			rdata_q <= i_dq_i;
		end
	end

	// ----------------------------------------------------------------
	// Flash pins, all from flip-flops.
	// ----------------------------------------------------------------
	// Write-enable controlled cycles: chip select stays low for the
	// whole operation, output enable stays high while data is driven.
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_ce_n  <= 1'b1;
			o_oe_n  <= 1'b1;
			o_we_n  <= 1'b1;
			o_dq_oe <= 1'b0;
		end else begin
			o_ce_n  <= state_d == flash_host_pkg::ST_IDLE;
			o_oe_n  <= state_d != flash_host_pkg::ST_RACC;
			o_we_n  <= state_d != flash_host_pkg::ST_WPUL;
			o_dq_oe <= state_d == flash_host_pkg::ST_WSET ||
				state_d == flash_host_pkg::ST_WPUL ||
				state_d == flash_host_pkg::ST_WREC;
		end
	end

	// Address and data; the poll keeps the last load address unchanged.
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_fl_addr <= 19'h00000;
			o_dq_o    <= 8'h00;
		end else begin
			if (start && i_wr_data[2:0] == flash_host_pkg::OP_WRITE) begin
				// Commands decode on the low bits only; upper bits low.
				o_fl_addr <= {4'h0,
					addr_q[flash_host_pkg::CMD_ADDR_BITS-1:0]};
			end else if (start &&
					i_wr_data[2:0] == flash_host_pkg::OP_PROG) begin
				o_fl_addr <= sect_addr(addr_q, 8'h00);
			end else if (start) begin
				o_fl_addr <= addr_q;
			end else if (state_q == flash_host_pkg::ST_WREC &&
					state_d == flash_host_pkg::ST_WSET) begin
				o_fl_addr <= sect_addr(addr_q, idx_q + 8'h01);
			end
			if (state_q == flash_host_pkg::ST_WSET &&
					state_d == flash_host_pkg::ST_WPUL) begin
				o_dq_o <= (op_q == flash_host_pkg::OP_PROG) ?
					buf_rdata : wdata_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// Software registers.
	// ----------------------------------------------------------------
	// Writes to the address and data registers while busy would corrupt
	// a running sequence, so they are taken only when idle.
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			addr_q  <= 19'h00000;
			wdata_q <= 8'h00;
			mask_q  <= '0;
			bidx_q  <= 8'h00;
		end else if (i_wr) begin
			if (i_addr == flash_host_pkg::REG_ADDR &&
					state_q == flash_host_pkg::ST_IDLE) begin
				addr_q <= i_wr_data[18:0];
			end
			if (i_addr == flash_host_pkg::REG_WDATA &&
					state_q == flash_host_pkg::ST_IDLE) begin
				wdata_q <= i_wr_data[7:0];
			end
			if (i_addr == flash_host_pkg::REG_IRQ_MASK) begin
				mask_q <= i_wr_data[EW-1:0];
			end
			if (i_addr == flash_host_pkg::REG_BUF_IDX) begin
				bidx_q <= i_wr_data[7:0];
			end else if (i_addr == flash_host_pkg::REG_BUF_DATA) begin
				bidx_q <= bidx_q + 8'h01;
			end
		end
	end

	// Events: a set in the same cycle as a clear wins.
	always_comb begin
		ev = '0;
		ev[flash_host_pkg::EV_DONE] = state_q != flash_host_pkg::ST_IDLE &&
			state_d == flash_host_pkg::ST_IDLE && !poll_tmo;
		ev[flash_host_pkg::EV_TIMEOUT] = poll_tmo;
		ev[flash_host_pkg::EV_REFUSED] = i_wr &&
			i_addr == flash_host_pkg::REG_CTRL &&
			state_q != flash_host_pkg::ST_IDLE;
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			stat_q <= '0;
		end else if (i_wr && i_addr == flash_host_pkg::REG_IRQ_STAT) begin
			stat_q <= (stat_q & ~i_wr_data[EW-1:0]) | ev;
		end else begin
			stat_q <= stat_q | ev;
		end
	end

	assign o_irq = |(stat_q & mask_q);

	// Read data stand in the cycle after the strobe; unmapped reads zero.
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_rd_data <= 32'h00000000;
		end else if (i_rd) begin
			unique case (i_addr)
				flash_host_pkg::REG_CTRL: o_rd_data <= {28'h0000000,
					state_q != flash_host_pkg::ST_IDLE, op_q};
				flash_host_pkg::REG_ADDR: o_rd_data <= {13'h0000, addr_q};
				flash_host_pkg::REG_WDATA: o_rd_data <= {24'h000000, wdata_q};
				flash_host_pkg::REG_RDATA: o_rd_data <= {24'h000000, rdata_q};
				flash_host_pkg::REG_IRQ_STAT: o_rd_data <= 32'(stat_q);
				flash_host_pkg::REG_IRQ_MASK: o_rd_data <= 32'(mask_q);
				flash_host_pkg::REG_BUF_IDX: o_rd_data <= {24'h000000, bidx_q};
				default: o_rd_data <= 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	logic [8:0]  loads_q;  // Strobes issued in a program operation.
	logic [15:0] gap_q;    // Cycles since the last load strobe.
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			loads_q <= 9'h000;
			gap_q   <= 16'h0000;
		end else begin
			loads_q <= start ? 9'h000 : loads_q + 9'($fell(o_we_n));
			gap_q   <= $fell(o_we_n) ? 16'h0000 : gap_q + 16'h0001;
		end
	end

	full_sector_a: assert property (
		state_q == flash_host_pkg::ST_WREC &&
		state_d == flash_host_pkg::ST_RACC |->
		loads_q == 9'(flash_host_pkg::SECTOR_BYTES))
		else $error("Polling began before a full sector was loaded.");
	sector_bits_a: assert property (
		$fell(o_we_n) && op_q == flash_host_pkg::OP_PROG |->
		o_fl_addr[18:8] == addr_q[18:8])
		else $error("Sector bits wrong at write strobe.");
	load_gap_a: assert property (
		$fell(o_we_n) && op_q == flash_host_pkg::OP_PROG &&
		loads_q != 9'h000 |-> gap_q < 16'(BLC_CYC))
		else $error("Byte load came after the load window.");
	cmd_addr_a: assert property (
		$fell(o_we_n) && op_q == flash_host_pkg::OP_WRITE |->
		o_fl_addr[18:15] == 4'h0 && o_dq_o == wdata_q)
		else $error("Command write with upper address bits set.");
	poll_addr_a: assert property (
		in_poll && $past(in_poll) |-> $stable(o_fl_addr))
		else $error("Address moved during polling.");
	poll_quiet_a: assert property (
		in_poll |-> ##1 o_we_n)
		else $error("Write strobe issued before completion.");
	oe_high_a: assert property (
		!o_we_n |-> o_oe_n && o_dq_oe)
		else $error("Output enable low during a load.");
	pulse_width_a: assert property (
		$fell(o_we_n) |-> (!o_we_n)[*8] ##15 !o_we_n ##1 o_we_n)
		else $error("Write pulse width is not exact.");
	done_irq_a: assert property (
		ev[flash_host_pkg::EV_DONE] && mask_q[flash_host_pkg::EV_DONE]
		|-> ##1 o_irq)
		else $error("Done event raised no interrupt.");

	prog_done_c: cover property (op_q == flash_host_pkg::OP_PROG &&
		ev[flash_host_pkg::EV_DONE]);
	timeout_c: cover property (poll_tmo);
	read_done_c: cover property (op_q == flash_host_pkg::OP_READ &&
		ev[flash_host_pkg::EV_DONE]);

endmodule

/* test/flash_model.sv */
`timescale 1ns/1ps

// Device stand-in: sector loads, self-timed program cycle, toggle status.
module flash_model (
	input  wire logic [18:0] i_addr,  // Address pins.
	input  wire logic        i_ce_n,  // Chip select, low active.
	input  wire logic        i_oe_n,  // Output enable, low active.
	input  wire logic        i_we_n,  // Write enable, low active.
	input  wire logic [7:0]  i_dq_o,  // Controller data.
	input  wire logic        i_dq_oe, // Controller drives data.
	input  wire logic        i_slow,  // Long program cycle when high.
	output logic      [7:0]  o_dq     // Resolved data wire.
);
	// Stand-in command codes and identity bytes; all values are arbitrary.
	localparam logic [14:0] CMD_A    = 15'h02AB;  // Command address.
	localparam logic [7:0]  C_ID_IN  = 8'h3C;     // Enter identification.
	localparam logic [7:0]  C_ID_OUT = 8'hC3;     // Leave identification.
	localparam logic [7:0]  C_PR_ON  = 8'h4B;     // Protection enable.
	localparam logic [7:0]  C_PR_OFF = 8'hB4;     // Protection disable.
	localparam logic [7:0]  C_LK_LO  = 8'h69;     // Lock lower boot block.
	localparam logic [7:0]  C_LK_HI  = 8'h96;     // Lock upper boot block.
	localparam logic [7:0]  MFR_ID   = 8'h5E;     // Maker code, arbitrary.
	localparam logic [7:0]  DEV_ID   = 8'h6D;     // Part code, arbitrary.
	logic [7:0]  mem [int];     // Array contents, sparse.
	logic [7:0]  page [int];    // Bytes loaded into this sector.
	logic [10:0] sect;          // Sector of the latest load.
	logic        busy = 1'b0;   // Program cycle running.
	logic        tog = 1'b0;    // Toggling status bit.
	logic [7:0]  dev_q;         // Value the device would drive.
	logic [7:0]  last = 8'h00;  // Last value driven.
	logic        rd_en;         // Device drives the wire.
	int          loads = 0;     // Loads in this sector.
	logic        id_mode = 1'b0;  // Off at power-up
	logic        prot = 1'b0;     // Write-protected state.
	logic [1:0]  pr_nxt = 2'b00;  // Pending change: valid, value.
	logic [1:0]  lock = 2'b00;    // Boot lockouts: upper, lower.

	assign rd_en = !i_ce_n && !i_oe_n && i_we_n;
	// A released wire shows the inverse of its last value, never a hold.
	assign o_dq = i_dq_oe ? i_dq_o : (rd_en ? dev_q : ~last);

	// Data is settled only by the strobe's rise, so bytes latch there;
	// writes to the command address never enter the sector.
	always @(posedge i_we_n) begin
		if (!i_ce_n && !busy && i_addr[14:0] == CMD_A) begin
			case (i_dq_o)
				C_ID_IN:  id_mode = 1'b1;
				C_ID_OUT: id_mode = 1'b0;
				C_PR_ON:  pr_nxt = 2'b11;
				C_PR_OFF: pr_nxt = 2'b10;
				C_LK_LO:  lock[0] = 1'b1;
				C_LK_HI:  lock[1] = 1'b1;
				default:  ;
			endcase
		end else if (!i_ce_n && !busy) begin
			page[i_addr[7:0]] = i_dq_o;
			sect = i_addr[18:8];
			loads++;
			if (loads == 256) begin
				busy = 1'b1;
				#(i_slow ? 10000 : 200);
				// Unloaded places get junk, not their old value.
				for (int k = 0; k < 256; k++) begin
					mem[{sect, k[7:0]}] = page.exists(k) ? page[k] : 8'h5A;
				end
				page.delete();
				loads = 0;
				// A pending protection change takes hold only now.
				if (pr_nxt[1]) prot = pr_nxt[0];
				pr_nxt = 2'b00;
				busy = 1'b0;
			end
		end
	end

	// Either enable falling advances the status bit while busy.
	always @(negedge i_oe_n or negedge i_ce_n) begin
		if (busy) begin
			tog = ~tog;
		end
	end

	always @* begin
		if (busy) begin
			dev_q = {1'b0, tog, 6'h00};
		end else if (id_mode && i_addr[18:1] == 18'h00000) begin
			dev_q = i_addr[0] ? DEV_ID : MFR_ID;
		end else if (id_mode && (i_addr == 19'h00002 ||
				i_addr == 19'h7FFF2)) begin
			dev_q = {7'h7F, lock[i_addr[18]]};
		end else begin
			dev_q = mem.exists(int'(i_addr)) ? mem[int'(i_addr)] : 8'hFF;
		end
	end

	always @(negedge rd_en) begin
		last = dev_q;
	end
endmodule

/* test/flash_host_ctrl_tb.sv */
`timescale 1ns/1ps

module flash_host_ctrl_tb;
	logic        i_mclk = 0, i_rst = 1, i_wr = 0, i_rd = 0, slow = 0;
	logic [7:0]  i_addr = 8'h00, dq_o, dq;
	logic [31:0] i_wr_data = 32'h0, o_rd_data, rd_q;
	logic [18:0] fl_addr, poll_exp;
	logic [10:0] sect_exp;
	logic        o_irq, ce_n, oe_n, we_n, dq_oe;
	int          err_count = 0, n_checks = 0, cyc = 0, loads, last_we;

	flash_host_ctrl #(.WC_CYC(200)) u_flash_host_ctrl (.i_mclk(i_mclk),
		.i_rst(i_rst), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr),
		.i_rd(i_rd), .o_rd_data(o_rd_data), .o_irq(o_irq),
		.o_fl_addr(fl_addr), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n),
		.o_dq_o(dq_o), .o_dq_oe(dq_oe), .i_dq_i(dq));
	flash_model u_flash_model (.i_addr(fl_addr), .i_ce_n(ce_n),
		.i_oe_n(oe_n), .i_we_n(we_n), .i_dq_o(dq_o), .i_dq_oe(dq_oe),
		.i_slow(slow), .o_dq(dq));

	initial forever #2 i_mclk = ~i_mclk;

	// A hung run is cut off well past the longest expected sequence.
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 80000) begin
			err_count++;
			summarize();
		end
	end

	// Each load strobe: enable high, sector steady, gap bounded, idle dev.
	always @(negedge we_n) begin
		loads++;
		chk("oe_load", oe_n, 1'b1);
		chk("sector", fl_addr[18:8], sect_exp);
		chk("dev_busy", u_flash_model.busy, 1'b0);
		if (loads > 1) chk("gap", (cyc - last_we) <
			flash_host_pkg::BYTE_LOAD_WINDOW_CYC, 1'b1);
		last_we = cyc;
	end

	// Status polls must all use one address.
	always @(negedge oe_n) begin
		if (u_flash_model.busy) chk("poll_addr", fl_addr, poll_exp);
	end

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_wr_data <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge i_mclk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 rd_q = o_rd_data;
	endtask

	// One edge first, so that a status clear just issued has landed.
	task automatic wait_irq(input int n);
		@(posedge i_mclk);
		for (int i = 0; i < n && o_irq !== 1'b1; i++) @(posedge i_mclk);
		chk("irq", o_irq, 1'b1);
	endtask

	// Whole sector, optional refused restart, then read back one byte.
	task automatic t_program(input logic [18:0] a, input logic [31:0] st,
		input logic poke);
		wr(flash_host_pkg::REG_BUF_IDX, 0);
		for (int k = 0; k < 256; k++) wr(flash_host_pkg::REG_BUF_DATA, a ^ k);
		wr(flash_host_pkg::REG_ADDR, a);
		sect_exp = a[18:8];
		poll_exp = {a[18:8], 8'hFF};
		loads = 0;
		wr(flash_host_pkg::REG_CTRL, 3);
		if (poke) begin
			wr(flash_host_pkg::REG_CTRL, 1);
			rd(flash_host_pkg::REG_CTRL);
			chk("ctrl_busy", rd_q, 32'hB);
			rd(flash_host_pkg::REG_IRQ_STAT);
			chk("refused", rd_q, 32'h4);
			wr(flash_host_pkg::REG_IRQ_STAT, 4);
		end
		wait_irq(20000);
		rd(flash_host_pkg::REG_IRQ_STAT);
		chk("stat", rd_q, st);
		chk("loads", loads, 256);
		wr(flash_host_pkg::REG_IRQ_STAT, 7);
		#1 chk("irq_clr", o_irq, 1'b0);
		if (st == 2) repeat (3000) @(posedge i_mclk);
		wr(flash_host_pkg::REG_ADDR, a | 19'h5);
		wr(flash_host_pkg::REG_CTRL, 2);
		wait_irq(200);
		rd(flash_host_pkg::REG_RDATA);
		if (st == 1) chk("readback", rd_q, (a ^ 5) & 8'hFF);
		wr(flash_host_pkg::REG_IRQ_STAT, 7);
	endtask

	// Command write with the mask closed: high address bits are cleared.
	task automatic t_cmd_write;
		wr(flash_host_pkg::REG_IRQ_MASK, 0);
		sect_exp = 11'h055;
		wr(flash_host_pkg::REG_ADDR, 19'h7D5AA);
		wr(flash_host_pkg::REG_WDATA, 8'hAA);
		wr(flash_host_pkg::REG_CTRL, 1);
		repeat (60) @(posedge i_mclk);
		chk("irq_masked", o_irq, 1'b0);
		rd(flash_host_pkg::REG_IRQ_STAT);
		chk("stat_w", rd_q, 32'h1);
		wr(flash_host_pkg::REG_IRQ_MASK, 7);
		#1 chk("irq_unmask", o_irq, 1'b1);
		wr(flash_host_pkg::REG_IRQ_STAT, 7);
		wr(flash_host_pkg::REG_CTRL, 4);
		wait_irq(300);
		rd(flash_host_pkg::REG_CTRL);
		chk("poll_idle", rd_q, 32'h4);
		wr(flash_host_pkg::REG_IRQ_STAT, 7);
	endtask

	// One command write at the command address, then clear its event.
	task automatic cmd(input logic [7:0] c);
		sect_exp = 11'(u_flash_model.CMD_A >> 8);
		wr(flash_host_pkg::REG_ADDR, u_flash_model.CMD_A);
		wr(flash_host_pkg::REG_WDATA, c);
		wr(flash_host_pkg::REG_CTRL, 1);
		wait_irq(100);
		wr(flash_host_pkg::REG_IRQ_STAT, 7);
	endtask

	// One array or identification read; the byte lands in rd_q.
	task automatic fl_read(input logic [18:0] a);
		wr(flash_host_pkg::REG_ADDR, a);
		wr(flash_host_pkg::REG_CTRL, 2);
		wait_irq(200);
		wr(flash_host_pkg::REG_IRQ_STAT, 7);
		rd(flash_host_pkg::REG_RDATA);
	endtask

	// Identification codes, lockout status, then back to the array.
	task automatic t_ident;
		cmd(u_flash_model.C_LK_HI);
		cmd(u_flash_model.C_ID_IN);
		fl_read(19'h00000);
		chk("mfr_code", rd_q, u_flash_model.MFR_ID);
		fl_read(19'h00001);
		chk("dev_code", rd_q, u_flash_model.DEV_ID);
		fl_read(19'h00002);
		chk("lock_lo", rd_q, 32'hFE);
		fl_read(19'h7FFF2);
		chk("lock_hi", rd_q, 32'hFF);
		cmd(u_flash_model.C_ID_OUT);
		fl_read(19'h12305);
		chk("array_back", rd_q, 32'h5);
	endtask

	task automatic summarize;
		if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge i_mclk);
		i_rst <= 1'b0;
		chk("reset_pins", {ce_n, oe_n, we_n, dq_oe, o_irq}, 5'h1C);
		rd(8'h20);
		chk("unmapped", rd_q, 32'h0);
		wr(flash_host_pkg::REG_IRQ_MASK, 7);
		cmd(u_flash_model.C_PR_ON);
		chk("prot_early", u_flash_model.prot, 1'b0);
		t_program(19'h12300, 1, 0);
		chk("prot_on", u_flash_model.prot, 1'b1);
		slow <= 1'b1;
		t_program(19'h45600, 2, 0);
		slow <= 1'b0;
		cmd(u_flash_model.C_PR_OFF);
		chk("prot_held", u_flash_model.prot, 1'b1);
		t_program(19'h7FF00, 1, 1);
		chk("prot_off", u_flash_model.prot, 1'b0);
		t_cmd_write();
		t_ident();
		summarize();
	end
endmodule
